// ### hdl/dmt_defs.svh
`ifndef DMT_DEFS_SVH
`define DMT_DEFS_SVH
// Register indices on the plain register port.
`define ADDR_SYSCTL1      4'h0
`define ADDR_SYSCTL2      4'h1
`define ADDR_IEN2         4'h2
`define ADDR_STATUS       4'h3
// Fields of system_control_one.
`define S1_STANDBY_BIT    7
`define S1_WATCH_BIT      6
`define S1_LOW_SPEED_BIT  3
`define S1_WAIT_LSB       0
// Fields of system_control_two.
`define S2_MEDIUM_BIT     0
`define S2_DIRECT_BIT     1
`define S2_SUBFREQ_LSB    2
// Field of interrupt_enable_two.
`define IEN2_DT_BIT       0
// State counts of a transition.
`define SLEEP_STATES      5'h02
`define INTERNAL_STATES   5'h01
`define EXC_STATES        5'h0E
// Medium-speed system clock divides the oscillator by eight.
`define MED_DIV           8'h08
`define WATCH_DIV_BASE    8'h02
`define SYSCTL1_RESET     8'h00
`define SYSCTL2_RESET     8'h00
`define IEN2_RESET        8'h00
`endif

// ### hdl/dmt_pkg.sv
package dmt_pkg;
   typedef enum logic [1:0] {MODE_HIGH, MODE_MED, MODE_SUB} op_mode_t;
   typedef enum logic [1:0] {
      PH_RUN, PH_SLEEP, PH_WATCH, PH_STANDBY
   } phase_t;
   typedef struct packed {
      logic       sleep_exec;
      logic       wake_req;
   } cpu_req_t;
   typedef struct packed {
      logic       cpu_clk_en;
      logic       dt_irq;
   } cpu_ans_t;
endpackage : dmt_pkg

// ### hdl/direct_mode_transition_ctrl.sv
// Notes on behaviour
// - Sleep with direct transition enabled switches mode, then raises interrupt.
// - Direct transition may also change frequency inside one operating mode.
// - Masked direct-transition interrupt leaves device in sleep or watch.
// - High-speed to medium-speed via sleep when standby 0, low 0, medium 1.
// - Medium-speed to high-speed via sleep when standby, low, medium all 0.
// - High-speed to subactive via watch when standby, watch, low all 1.
// - Medium-speed to subactive via watch when standby, watch, low all 1.
// - Subactive to high-speed via watch after standby wait, medium 0.
// - Subactive to medium-speed via watch after standby wait, medium 1.
// - High to medium: three states old clock, fourteen states new clock.
// - Medium to high: sleep states old period, exception states new.
// - High to subactive: exception states counted at subclock period.
// - Medium to subactive: sleep at medium period, exception at subclock.
// - Subactive to high: subclock sleep, then wait plus exception states.
// - Subactive to medium: wait and exception states at medium period.
// - Subactive rate is watch clock over two, four, eight or sixteen.
`timescale 1ns/1ps
`default_nettype none
`include "dmt_defs.svh"
module direct_mode_transition_ctrl #(
   parameter int OSC_DIV_MED = 8,
   parameter int WAIT_UNIT   = 1
) (
   // Clock and reset.
   input  wire logic              clock,
   input  wire logic              rst_n,
   // Register port.
   input  wire logic [3:0]        addr,
   input  wire logic [7:0]        wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output logic [7:0]             rdata,
   // CPU side.
   input  wire dmt_pkg::cpu_req_t cpu_req,
   input  wire logic              global_int_mask,
   output dmt_pkg::cpu_ans_t      cpu_ans,
   output logic                   cpu_clk_tick,
   // Clock-source side.
   output dmt_pkg::op_mode_t      op_mode,
   output dmt_pkg::phase_t        phase,
   output logic                   sys_osc_en
);
   logic [7:0] system_control_one;
   logic [7:0] system_control_two;
   logic [7:0] interrupt_enable_two;
   logic [1:0] wake_sync;
   logic       wake;
   dmt_pkg::op_mode_t next_op_mode;
   dmt_pkg::op_mode_t target;
   dmt_pkg::phase_t   next_phase;
   logic [15:0] wait_cnt;
   logic [4:0]  state_cnt;
   logic [7:0]  div_cnt;
   logic        in_exc;
   logic        pending;

   wire software_standby_select = system_control_one[`S1_STANDBY_BIT];
   wire watch_mode_select       = system_control_one[`S1_WATCH_BIT];
   wire low_speed_select        = system_control_one[`S1_LOW_SPEED_BIT];
   wire [2:0] standby_wait_time_field = system_control_one[`S1_WAIT_LSB +: 3];
   wire medium_speed_select     = system_control_two[`S2_MEDIUM_BIT];
   wire direct_transition_enable = system_control_two[`S2_DIRECT_BIT];
   wire [1:0] subactive_freq_field = system_control_two[`S2_SUBFREQ_LSB +: 2];
   wire dt_int_enable = interrupt_enable_two[`IEN2_DT_BIT];

   // Decode of the sleep-time mode bits.
   wire sel_sleep = !software_standby_select && !low_speed_select;
   wire sel_sub   = software_standby_select && watch_mode_select
                    && low_speed_select;
   wire sel_act_w = software_standby_select && watch_mode_select
                    && !low_speed_select;
   wire sel_stby  = software_standby_select && !watch_mode_select;
   wire from_sub  = (op_mode == dmt_pkg::MODE_SUB);
   wire dt_go     = direct_transition_enable && dt_int_enable
                    && !global_int_mask;

   // Divider per mode: one tick per state of the current CPU clock.
   // subactive divider
   wire [7:0] sub_div = `WATCH_DIV_BASE << subactive_freq_field;
   // wait at new clock
   // The standby wait already runs on the clock of the mode being entered.
   wire waiting = (phase != dmt_pkg::PH_RUN) && pending
                  && (state_cnt == 5'h00) && (wait_cnt != 16'h0);
   dmt_pkg::op_mode_t div_mode;
   assign div_mode = waiting ? target : op_mode;
   wire [7:0] cur_div = (div_mode == dmt_pkg::MODE_SUB) ? sub_div :
                        (div_mode == dmt_pkg::MODE_MED) ? 8'(OSC_DIV_MED) :
                        8'h01;
   wire tick = (div_cnt >= cur_div - 8'h01);

   // Standby wait in states of the new clock, from the three-bit field.
   // The shift amount is four bits wide so the largest field does not wrap.
   wire [3:0]  wait_shift  = {1'b0, standby_wait_time_field} + 4'h3;
   wire [15:0] wait_states = 16'(WAIT_UNIT) << wait_shift;
   wire [4:0]  pre_states  = `SLEEP_STATES + `INTERNAL_STATES;

   always_comb begin
      next_op_mode = op_mode;
      next_phase   = phase;
      target       = op_mode;
      if (sel_sleep && !from_sub)
         target = medium_speed_select ? dmt_pkg::MODE_MED
                                      : dmt_pkg::MODE_HIGH;
      else if (sel_sub && !from_sub)
         target = dmt_pkg::MODE_SUB;
      else if (sel_act_w && from_sub)
         target = medium_speed_select ? dmt_pkg::MODE_MED
                                      : dmt_pkg::MODE_HIGH;
      case (phase)
         dmt_pkg::PH_RUN: begin
            if (cpu_req.sleep_exec && state_cnt == 5'h00) begin
               if (sel_sleep)
                  next_phase = dmt_pkg::PH_SLEEP;
               else if (sel_stby && !from_sub)
                  next_phase = dmt_pkg::PH_STANDBY;
               else
                  next_phase = dmt_pkg::PH_WATCH;
            end
         end
         default: begin
            if (pending && tick && state_cnt == 5'h00 && wait_cnt == 16'h0)
               next_op_mode = target;
            if (pending && tick && state_cnt == 5'h00 && wait_cnt == 16'h0)
               next_phase = dmt_pkg::PH_RUN;
            else if (!pending && wake && !global_int_mask)
               next_phase = dmt_pkg::PH_RUN;
         end
      endcase
   end

   // Register port; read data valid the cycle after the strobe.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         system_control_one   <= `SYSCTL1_RESET;
         system_control_two   <= `SYSCTL2_RESET;
         interrupt_enable_two <= `IEN2_RESET;
      end else if (wr) begin
         if (addr == `ADDR_SYSCTL1)
            system_control_one <= wdata;
         if (addr == `ADDR_SYSCTL2)
            system_control_two <= wdata;
         if (addr == `ADDR_IEN2)
            interrupt_enable_two <= wdata;
      end
   end

   wire [7:0] status = {2'h0, in_exc, pending, phase, op_mode};
   wire [7:0] rd_mux = (addr == `ADDR_SYSCTL1) ? system_control_one :
                       (addr == `ADDR_SYSCTL2) ? system_control_two :
                       (addr == `ADDR_IEN2)    ? interrupt_enable_two :
                       (addr == `ADDR_STATUS)  ? status : 8'h00;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         rdata <= 8'h00;
      else
         rdata <= rd ? rd_mux : 8'h00;
   end

   // Wake input is asynchronous; two flops before use.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         wake_sync <= 2'h0;
      else
         wake_sync <= {wake_sync[0], cpu_req.wake_req};
   end
   assign wake = wake_sync[1];

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         div_cnt <= 8'h00;
      else if (tick)
         div_cnt <= 8'h00;
      else
         div_cnt <= div_cnt + 8'h01;
   end

   // Sequencer: counts are taken per tick of the clock then in force.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         op_mode   <= dmt_pkg::MODE_HIGH;
         phase     <= dmt_pkg::PH_RUN;
         pending   <= 1'b0;
         state_cnt <= 5'h00;
         wait_cnt  <= 16'h0;
         in_exc    <= 1'b0;
      end else begin
         op_mode <= next_op_mode;
         phase   <= next_phase;
         if (phase == dmt_pkg::PH_RUN && next_phase != dmt_pkg::PH_RUN) begin
            pending <= dt_go && (target != op_mode || sel_sleep
                                 || sel_sub || sel_act_w);
            state_cnt <= pre_states - 5'h01;
            wait_cnt <= (from_sub && sel_act_w) ? wait_states : 16'h0;
         end else if (phase != dmt_pkg::PH_RUN && pending && tick) begin
            if (state_cnt != 5'h00)
               state_cnt <= state_cnt - 5'h01;
            else if (wait_cnt != 16'h0)
               wait_cnt <= wait_cnt - 16'h1;
         end
         if (phase != dmt_pkg::PH_RUN && next_phase == dmt_pkg::PH_RUN) begin
            pending   <= 1'b0;
            in_exc    <= 1'b1;
            state_cnt <= `EXC_STATES;
         end else if (in_exc && tick) begin
            if (state_cnt == 5'h01)
               in_exc <= 1'b0;
            state_cnt <= state_cnt - 5'h01;
         end
      end
   end

   assign cpu_ans.dt_irq = (phase != dmt_pkg::PH_RUN)
                           && (next_phase == dmt_pkg::PH_RUN);
   assign cpu_ans.cpu_clk_en = (phase == dmt_pkg::PH_RUN);
   assign cpu_clk_tick = tick && (phase == dmt_pkg::PH_RUN);
   // oscillator stays on unless sub or stopped
   assign sys_osc_en = (op_mode != dmt_pkg::MODE_SUB)
                       && (phase != dmt_pkg::PH_WATCH)
                       && (phase != dmt_pkg::PH_STANDBY);
endmodule : direct_mode_transition_ctrl
`default_nettype wire

// ### dv/dmt_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dmt_chk (
   input wire logic              clock,
   input wire logic              rst_n,
   input wire logic              rd,
   input wire logic [7:0]        rdata,
   input wire dmt_pkg::cpu_req_t cpu_req,
   input wire logic              global_int_mask,
   input wire dmt_pkg::cpu_ans_t cpu_ans,
   input wire logic              cpu_clk_tick,
   input wire dmt_pkg::op_mode_t op_mode,
   input wire dmt_pkg::phase_t   phase
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   wire run = (phase == dmt_pkg::PH_RUN);
   sequence s_left;
      !run && $past(run);
   endsequence
   sequence s_slept;
      $past(cpu_req.sleep_exec) || $past(cpu_req.sleep_exec, 2);
   endsequence
   a_clock_gate: assert property (cpu_ans.cpu_clk_en == run)
      else $error("cpu clock enable differs from run phase");
   a_no_tick_mid: assert property (!run |-> !cpu_clk_tick)
      else $error("cpu tick outside run phase");
   a_irq_resume: assert property (cpu_ans.dt_irq |-> !run ##1 run)
      else $error("interrupt start not followed by run");
   a_irq_pulse: assert property (cpu_ans.dt_irq |=> !cpu_ans.dt_irq)
      else $error("interrupt start longer than one cycle");
   a_mode_on_irq: assert property ($changed(op_mode) |-> $past(cpu_ans.dt_irq))
      else $error("mode changed without interrupt start");
   a_mask_holds: assert property (!run && global_int_mask |=> !run)
      else $error("left sleep while masked");
   a_sleep_cause: assert property (s_left |-> s_slept)
      else $error("left run without sleep");
   a_read_idle: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data outside read answer cycle");
endmodule : dmt_chk
bind direct_mode_transition_ctrl dmt_chk u_chk (.clock(clock), .rst_n(rst_n),
   .rd(rd), .rdata(rdata), .cpu_req(cpu_req), .global_int_mask(global_int_mask),
   .cpu_ans(cpu_ans), .cpu_clk_tick(cpu_clk_tick), .op_mode(op_mode),
   .phase(phase));
`default_nettype wire

// ### dv/cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
   input  wire logic              clock,
   input  wire dmt_pkg::cpu_ans_t cpu_ans,
   output var dmt_pkg::cpu_req_t  cpu_req
);
   initial cpu_req = '0;
   task automatic do_sleep;
      while (!cpu_ans.cpu_clk_en) @(posedge clock);
      cpu_req.sleep_exec <= 1'b1;
      @(posedge clock);
      cpu_req.sleep_exec <= 1'b0;
   endtask : do_sleep
   // wake held four cycles, so capture is safe after a stopped clock.
   task automatic do_wake;
      cpu_req.wake_req <= 1'b1;
      repeat (4) @(posedge clock);
      cpu_req.wake_req <= 1'b0;
   endtask : do_wake
endmodule : cpu_model
`default_nettype wire

// ### dv/direct_mode_transition_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module direct_mode_transition_ctrl_tb;
   logic              clock = 1'b0;
   logic              rst_n = 1'b0;
   logic              wr = 1'b0;
   logic              rd = 1'b0;
   logic              global_int_mask = 1'b0;
   logic [3:0]        addr = 4'h0;
   logic [7:0]        wdata = 8'h00;
   logic [7:0]        rdata;
   logic [7:0]        v;
   dmt_pkg::cpu_req_t cpu_req;
   dmt_pkg::cpu_ans_t cpu_ans;
   dmt_pkg::op_mode_t op_mode;
   dmt_pkg::phase_t   phase;
   logic              cpu_clk_tick;
   logic              sys_osc_en;
   int                n_errors = 0;
   int                n_compared = 0;
   int                cyc = 0;
   logic [7:0]        s1[6] = '{8'h00, 8'h00, 8'hC8, 8'hC0, 8'hC8, 8'hC0};
   logic [7:0]        s2[6] = '{8'h03, 8'h02, 8'h02, 8'h0F, 8'h02, 8'h02};
   logic [7:0]        md[6] = '{8'h01, 8'h00, 8'h02, 8'h01, 8'h02, 8'h00};
   always #25 clock = ~clock;
   direct_mode_transition_ctrl dut (.clock(clock), .rst_n(rst_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cpu_req(cpu_req),
      .global_int_mask(global_int_mask), .cpu_ans(cpu_ans),
      .cpu_clk_tick(cpu_clk_tick), .op_mode(op_mode), .phase(phase),
      .sys_osc_en(sys_osc_en));
   cpu_model cpu (.clock(clock), .cpu_ans(cpu_ans), .cpu_req(cpu_req));
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      @(negedge clock);
      d = rdata;
      @(posedge clock);
   endtask : rd_reg
   // Polls status until back in run with the exception count over.
   task automatic settle;
      for (int k = 0; k < 3000; k++) begin
         rd_reg(4'h3, v);
         if (v[5:2] === 4'b0000) break;
      end
   endtask : settle
   task automatic print_verdict;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : print_verdict
   always @(posedge clock) begin
      cyc++;
      if (cyc == 60000) begin
         n_errors++;
         print_verdict();
      end
   end
   initial begin
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      for (int i = 0; i < 3; i++) begin
         rd_reg(i[3:0], v);
         check(v, 8'h00);
      end
      wr_reg(4'hF, 8'h5A);
      rd_reg(4'hF, v);
      check(v, 8'h00);
      wr_reg(4'h2, 8'h01);
      for (int i = 0; i < 6; i++) begin
         wr_reg(4'h0, s1[i]);
         wr_reg(4'h1, s2[i]);
         cpu.do_sleep();
         repeat (2) @(posedge clock);
         settle();
         check({6'h00, op_mode}, md[i]);
         check({7'h00, sys_osc_en}, (md[i] == 8'h02) ? 8'h00 : 8'h01);
      end
      wr_reg(4'h2, 8'h00);
      wr_reg(4'h0, 8'h00);
      cpu.do_sleep();
      repeat (4) @(posedge clock);
      check({6'h00, phase}, 8'h01);
      cpu.do_wake();
      settle();
      check({6'h00, phase}, 8'h00);
      global_int_mask <= 1'b1;
      cpu.do_sleep();
      cpu.do_wake();
      repeat (20) @(posedge clock);
      check({6'h00, phase}, 8'h01);
      rst_n <= 1'b0;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      global_int_mask <= 1'b0;
      @(posedge clock);
      check({4'h0, op_mode, phase}, 8'h00);
      print_verdict();
   end
endmodule : direct_mode_transition_ctrl_tb
`default_nettype wire
